//--- rtl/cacm_pkg.sv
package cacm_pkg;
   // ------------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_MODE    = 8'h04;
   localparam logic [7:0] ADDR_PWMCFG  = 8'h08;
   localparam logic [7:0] ADDR_CMP_LO  = 8'h0c;
   localparam logic [7:0] ADDR_CMP_HI  = 8'h10;
   localparam logic [7:0] ADDR_COUNTER = 8'h14;
   localparam logic [7:0] ADDR_PINLVL  = 8'h18;
   localparam int         ADDR_W       = 8;

   // ------------------------------------------------------------------
   // control register bits
   // ------------------------------------------------------------------
   localparam int CTRL_EVT  = 0;
   localparam int CTRL_RUN  = 1;
   localparam int CTRL_CYCLE_OVERFLOW_FLAG = 2;
   localparam int CTRL_WRAP = 3;

   // ------------------------------------------------------------------
   // mode register bits
   // ------------------------------------------------------------------
   localparam int MODE_IRQ  = 0;
   localparam int MODE_PWM  = 1;
   localparam int MODE_TOG  = 2;
   localparam int MODE_MAT  = 3;
   localparam int MODE_FALL = 4;
   localparam int MODE_RISE = 5;
   localparam int MODE_CMP  = 6;
   localparam int MODE_W16  = 7;
   localparam int MODE_W    = 8;

   // ------------------------------------------------------------------
   // pwm config register bits
   // ------------------------------------------------------------------
   localparam int PCFG_CLS_LO = 0;
   localparam int PCFG_CLS_HI = 1;
   localparam int PCFG_COVIE  = 5;
   localparam int PCFG_CYCLE_OVERFLOW_FLAG   = 6;
   localparam int PCFG_VIEW   = 7;

   // ------------------------------------------------------------------
   // constants
   // ------------------------------------------------------------------
   localparam logic [1:0]  CLS_8      = 2'h0;
   localparam logic [7:0]  BYTE_MAX   = 8'hff;
   localparam logic [15:0] CNT_MAX    = 16'hffff;
   localparam logic [1:0]  HTRANS_NSQ = 2'h2;
   localparam logic [31:0] RD_ZERO    = 32'h00000000;
endpackage : cacm_pkg

//--- rtl/cacm_channel.sv
`timescale 1ns/10ps
module cacm_channel #(
   parameter int CHANNELS = 1
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        timebase_tick,
   input  wire logic        channel_pin_in,
   output logic             channel_pin_out,
   output logic             channel_pin_oe,
   output logic             irq
);
   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   logic [15:0]                  counter_ff;
   logic                         run_ff;
   logic [15:0]                  cmp_ff;
   logic [15:0]                  reload_ff;
   logic [cacm_pkg::MODE_W-1:0]  mode_ff;
   logic [1:0]                   cls_ff;
   logic                         view_ff;
   logic                         covie_ff;
   logic                         evt_ff;
   logic                         cycle_overflow_flag_ff;
   logic                         wrap_ff;
   logic                         pin_ff;
   logic                         sync1_ff;
   logic                         sync2_ff;
   logic                         sync3_ff;
   logic                         wr_ph_ff;
   logic [cacm_pkg::ADDR_W-1:0]  wr_addr_ff;
   logic [31:0]                  hrdata_ff;
   logic                         irq_ff;

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   function automatic logic [10:0] len_mask(input logic [1:0] cls);
      len_mask = 11'((16'h0100 << cls) - 16'h0001);
   endfunction : len_mask

   function automatic logic wr_hit(input logic ph, input logic [7:0] a, input logic [7:0] r);
      wr_hit = ph && (a == r);
   endfunction : wr_hit

   // ------------------------------------------------------------------
   // mode decode
   // ------------------------------------------------------------------
   logic        cmp_en, mat_en, tog_en, pwm_en_b, w16_en;
   logic        cap_mode, tmr_mode, hso_mode, frq_mode, pw16_mode, pwn_mode;
   logic [10:0] msk;
   logic        tick, full_match, n_match, n_ovf, lo_match, cap_evt;
   logic        rise, fall;

   assign cmp_en    = mode_ff[cacm_pkg::MODE_CMP];
   assign mat_en    = mode_ff[cacm_pkg::MODE_MAT];
   assign tog_en    = mode_ff[cacm_pkg::MODE_TOG];
   assign pwm_en_b  = mode_ff[cacm_pkg::MODE_PWM];
   assign w16_en    = mode_ff[cacm_pkg::MODE_W16];
   assign cap_mode  = !pwm_en_b && !tog_en && (mode_ff[cacm_pkg::MODE_RISE] || mode_ff[cacm_pkg::MODE_FALL]);
   assign tmr_mode  = !pwm_en_b && !tog_en && !cap_mode;
   assign hso_mode  = !pwm_en_b && tog_en;
   assign frq_mode  = pwm_en_b && tog_en;
   assign pw16_mode = pwm_en_b && !tog_en && w16_en;
   assign pwn_mode  = pwm_en_b && !tog_en && !w16_en;
   assign msk       = len_mask(cls_ff);
   assign tick      = run_ff && timebase_tick;
   assign full_match = tick && (counter_ff == cmp_ff);
   assign n_match   = tick && ((counter_ff[10:0] & msk) == (cmp_ff[10:0] & msk));
   assign n_ovf     = tick && ((counter_ff[10:0] & msk) == msk);
   assign lo_match  = tick && (counter_ff[7:0] == cmp_ff[7:0]);
   assign rise      = sync2_ff && !sync3_ff;
   assign fall      = !sync2_ff && sync3_ff;
   assign cap_evt   = cap_mode && ((rise && mode_ff[cacm_pkg::MODE_RISE])
                                   || (fall && mode_ff[cacm_pkg::MODE_FALL]));

   // ------------------------------------------------------------------
   // bus
   // ------------------------------------------------------------------
   logic acc, wr_ctrl, wr_mode, wr_pcfg, wr_lo, wr_hi, wr_cnt;
   assign acc     = hsel && hready && (htrans == cacm_pkg::HTRANS_NSQ);
   assign wr_ctrl = wr_hit(wr_ph_ff, wr_addr_ff, cacm_pkg::ADDR_CTRL);
   assign wr_mode = wr_hit(wr_ph_ff, wr_addr_ff, cacm_pkg::ADDR_MODE);
   assign wr_pcfg = wr_hit(wr_ph_ff, wr_addr_ff, cacm_pkg::ADDR_PWMCFG);
   assign wr_lo   = wr_hit(wr_ph_ff, wr_addr_ff, cacm_pkg::ADDR_CMP_LO);
   assign wr_hi   = wr_hit(wr_ph_ff, wr_addr_ff, cacm_pkg::ADDR_CMP_HI);
   assign wr_cnt  = wr_hit(wr_ph_ff, wr_addr_ff, cacm_pkg::ADDR_COUNTER);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ph_ff   <= 1'b0;
         wr_addr_ff <= '0;
      end else begin
         wr_ph_ff   <= acc && hwrite && (hsize == 3'h2);
         wr_addr_ff <= haddr[cacm_pkg::ADDR_W-1:0];
      end
   end

   logic        use_rl;
   logic [31:0] rd;
   assign use_rl = view_ff && pwn_mode && (cls_ff != cacm_pkg::CLS_8);
   always_comb begin
      rd = cacm_pkg::RD_ZERO;
      unique case (haddr[cacm_pkg::ADDR_W-1:0])
         cacm_pkg::ADDR_CTRL:    rd = {28'h0000000, wrap_ff, cycle_overflow_flag_ff, run_ff, evt_ff};
         cacm_pkg::ADDR_MODE:    rd = {24'h000000, mode_ff};
         cacm_pkg::ADDR_PWMCFG:  rd = {24'h000000, view_ff, cycle_overflow_flag_ff, covie_ff, 3'h0, cls_ff};
         cacm_pkg::ADDR_CMP_LO:  rd = {24'h000000, use_rl ? reload_ff[7:0] : cmp_ff[7:0]};
         cacm_pkg::ADDR_CMP_HI:  rd = {24'h000000, use_rl ? reload_ff[15:8] : cmp_ff[15:8]};
         cacm_pkg::ADDR_COUNTER: rd = {16'h0000, counter_ff};
         cacm_pkg::ADDR_PINLVL:  rd = {31'h00000000, sync2_ff};
         default:                rd = cacm_pkg::RD_ZERO;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_ff <= cacm_pkg::RD_ZERO;
      end else if (acc && !hwrite) begin
         hrdata_ff <= rd;
      end
   end
   assign hrdata    = hrdata_ff;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // ------------------------------------------------------------------
   // pin synchroniser
   // ------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         sync3_ff <= 1'b0;
      end else begin
         sync1_ff <= channel_pin_in;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
      end
   end

   // ------------------------------------------------------------------
   // counter and wrap flag
   // ------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         counter_ff <= '0;
         run_ff     <= 1'b0;
         wrap_ff    <= 1'b0;
      end else begin
         if (wr_cnt) begin
            counter_ff <= hwdata[15:0];
         end else if (tick) begin
            counter_ff <= counter_ff + 16'h0001;
         end
         if (wr_ctrl) begin
            run_ff <= hwdata[cacm_pkg::CTRL_RUN];
         end
         if (tick && counter_ff == cacm_pkg::CNT_MAX) begin
            wrap_ff <= 1'b1;
         end else if (wr_ctrl) begin
            wrap_ff <= hwdata[cacm_pkg::CTRL_WRAP];
         end
      end
   end

   // ------------------------------------------------------------------
   // configuration
   // ------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_ff  <= '0;
         cls_ff   <= cacm_pkg::CLS_8;
         view_ff  <= 1'b0;
         covie_ff <= 1'b0;
      end else begin
         if (wr_lo && !use_rl) begin
            mode_ff[cacm_pkg::MODE_CMP] <= 1'b0;
         end else if (wr_hi && !use_rl) begin
            mode_ff[cacm_pkg::MODE_CMP] <= 1'b1;
         end else if (wr_mode) begin
            mode_ff <= hwdata[cacm_pkg::MODE_W-1:0];
         end
         if (wr_pcfg) begin
            cls_ff   <= hwdata[cacm_pkg::PCFG_CLS_HI:cacm_pkg::PCFG_CLS_LO];
            view_ff  <= hwdata[cacm_pkg::PCFG_VIEW];
            covie_ff <= hwdata[cacm_pkg::PCFG_COVIE];
         end
      end
   end

   // ------------------------------------------------------------------
   // compare and reload registers
   // ------------------------------------------------------------------
   logic [7:0] step;
   assign step = cmp_ff[15:8]; // zero wraps as 256
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmp_ff    <= '0;
         reload_ff <= '0;
      end else begin
         if (use_rl && wr_lo) begin
            reload_ff[7:0] <= hwdata[7:0];
         end
         if (use_rl && wr_hi) begin
            reload_ff[15:8] <= hwdata[7:0];
         end
         if (cap_evt) begin
            cmp_ff <= counter_ff;
         end else if (!use_rl && wr_lo) begin
            cmp_ff[7:0] <= hwdata[7:0];
         end else if (!use_rl && wr_hi) begin
            cmp_ff[15:8] <= hwdata[7:0];
         end else if (frq_mode && cmp_en && lo_match) begin
            cmp_ff[7:0] <= cmp_ff[7:0] + step;
         end else if (pwn_mode && cls_ff == cacm_pkg::CLS_8 && tick
                      && counter_ff[7:0] == cacm_pkg::BYTE_MAX) begin
            cmp_ff[7:0] <= cmp_ff[15:8];
         end else if (pwn_mode && cls_ff != cacm_pkg::CLS_8 && n_ovf) begin
            cmp_ff <= reload_ff;
         end
      end
   end

   // ------------------------------------------------------------------
   // pin output
   // ------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_ff <= 1'b0;
      end else if ((pwn_mode || pw16_mode) && !cmp_en) begin
         pin_ff <= 1'b0;
      end else if (pwn_mode && n_ovf) begin
         pin_ff <= 1'b0;
      end else if (pwn_mode && n_match) begin
         pin_ff <= 1'b1;
      end else if (pw16_mode && tick && counter_ff == cacm_pkg::CNT_MAX) begin
         pin_ff <= 1'b0;
      end else if (pw16_mode && full_match) begin
         pin_ff <= 1'b1;
      end else if (hso_mode && cmp_en && mat_en && full_match) begin
         pin_ff <= !pin_ff;
      end else if (frq_mode && cmp_en && lo_match) begin
         pin_ff <= !pin_ff;
      end
   end
   assign channel_pin_out = pin_ff;
   logic oe_ff;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         oe_ff <= 1'b0;
      end else begin
         oe_ff <= !cap_mode && !tmr_mode;
      end
   end
   assign channel_pin_oe  = oe_ff;

   // ------------------------------------------------------------------
   // event flags and interrupt
   // ------------------------------------------------------------------
   logic evt_set, cycle_overflow_flag_set;
   assign evt_set = cap_evt
                 || (mat_en && cmp_en && (tmr_mode || hso_mode || pw16_mode) && full_match)
                 || (frq_mode && mat_en && full_match)
                 || (pwn_mode && mat_en && cmp_en && n_match);
   assign cycle_overflow_flag_set = pwn_mode && n_ovf;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         evt_ff  <= 1'b0;
         cycle_overflow_flag_ff <= 1'b0;
         irq_ff  <= 1'b0;
      end else begin
         if (evt_set) begin
            evt_ff <= 1'b1;
         end else if (wr_ctrl) begin
            evt_ff <= hwdata[cacm_pkg::CTRL_EVT];
         end
         if (cycle_overflow_flag_set) begin
            cycle_overflow_flag_ff <= 1'b1;
         end else if (wr_ctrl) begin
            cycle_overflow_flag_ff <= hwdata[cacm_pkg::CTRL_CYCLE_OVERFLOW_FLAG];
         end
         irq_ff <= (evt_ff && mode_ff[cacm_pkg::MODE_IRQ]) || (cycle_overflow_flag_ff && covie_ff);
      end
   end
   assign irq = irq_ff;
endmodule : cacm_channel

//--- test/cacm_pin_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------------
// pin source and load
// ------------------------------------------------------------------
module cacm_pin_model (
   input  wire logic hclk,
   input  wire logic ext_lvl,
   input  wire logic pin_out,
   input  wire logic pin_oe,
   output logic      pin_in
);
   logic lvl_ff;
   always_ff @(posedge hclk) lvl_ff <= ext_lvl;
   assign pin_in = pin_oe ? pin_out : lvl_ff;
endmodule : cacm_pin_model

//--- test/cacm_channel_monitor.sv
`timescale 1ns/10ps
module cacm_channel_monitor #(
   parameter int CHANNELS = 1
) (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        timebase_tick,
   input wire logic        channel_pin_in,
   input wire logic        channel_pin_out,
   input wire logic        channel_pin_oe,
   input wire logic        irq
);
   // ------------------------------------------------------------------
   // bus shadow of mode and pwm config
   // ------------------------------------------------------------------
   logic       ap_vld_ff;
   logic       ap_wr_ff;
   logic [7:0] ap_a_ff;
   logic [7:0] mode_ff;
   logic [7:0] pcfg_ff;
   logic [3:0] wr_hist_ff;
   logic       wr_done;
   assign wr_done = ap_vld_ff && ap_wr_ff;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_vld_ff  <= 1'b0;
         ap_wr_ff   <= 1'b0;
         ap_a_ff    <= 8'h00;
         wr_hist_ff <= 4'h0;
      end else begin
         ap_vld_ff  <= hsel && hready && htrans == cacm_pkg::HTRANS_NSQ;
         ap_wr_ff   <= hwrite;
         ap_a_ff    <= haddr[7:0];
         wr_hist_ff <= {wr_hist_ff[2:0], wr_done};
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_ff <= 8'h00;
         pcfg_ff <= 8'h00;
      end else if (wr_done) begin
         if (ap_a_ff == cacm_pkg::ADDR_MODE) mode_ff <= hwdata[7:0];
         if (ap_a_ff == cacm_pkg::ADDR_PWMCFG) pcfg_ff <= hwdata[7:0];
         if (ap_a_ff == cacm_pkg::ADDR_CMP_LO && !pcfg_ff[cacm_pkg::PCFG_VIEW]) mode_ff[cacm_pkg::MODE_CMP] <= 1'b0;
         if (ap_a_ff == cacm_pkg::ADDR_CMP_HI && !pcfg_ff[cacm_pkg::PCFG_VIEW]) mode_ff[cacm_pkg::MODE_CMP] <= 1'b1;
      end
   end
   default clocking dc @(posedge hclk); endclocking
   default disable iff (!hresetn);
   chk_no_wait: assert property (hreadyout)
      else $error("hreadyout low");
   chk_resp_okay: assert property (!hresp)
      else $error("hresp not okay");
   chk_mode_rdbk: assert property (
      ap_vld_ff && !ap_wr_ff && ap_a_ff == cacm_pkg::ADDR_MODE |-> hrdata[7:0] == mode_ff)
      else $error("mode readback wrong");
   chk_unmapped_zero: assert property (
      ap_vld_ff && !ap_wr_ff && ap_a_ff > cacm_pkg::ADDR_PINLVL |-> hrdata == cacm_pkg::RD_ZERO)
      else $error("unmapped read not zero");
   chk_oe_mode: assert property (
      channel_pin_oe == ($past(mode_ff[cacm_pkg::MODE_PWM]) || $past(mode_ff[cacm_pkg::MODE_TOG])))
      else $error("pin enable wrong for mode");
   chk_pwm_off_low: assert property (
      (mode_ff[cacm_pkg::MODE_PWM] && !mode_ff[cacm_pkg::MODE_TOG] && !mode_ff[cacm_pkg::MODE_CMP]) [*2]
      |-> !channel_pin_out) else $error("pwm pin high with comparator off");
   chk_hold_pin: assert property (
      mode_ff[cacm_pkg::MODE_TOG] && !mode_ff[cacm_pkg::MODE_CMP] |-> $stable(channel_pin_out))
      else $error("pin moved with comparator off");
   chk_irq_src: assert property (
      $rose(irq) |-> $past(mode_ff[cacm_pkg::MODE_IRQ]) || $past(pcfg_ff[cacm_pkg::PCFG_COVIE]))
      else $error("irq rose without enable");
   chk_evt_hold: assert property (
      $fell(irq) |-> wr_hist_ff != 4'h0)
      else $error("irq fell without write");
   cover property (wr_done && ap_a_ff == cacm_pkg::ADDR_CMP_HI);
   cover property ($rose(irq));
   cover property (mode_ff[cacm_pkg::MODE_PWM] && $fell(channel_pin_out));
endmodule : cacm_channel_monitor

bind cacm_channel cacm_channel_monitor #(.CHANNELS(CHANNELS)) u_mon (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .timebase_tick(timebase_tick), .channel_pin_in(channel_pin_in), .channel_pin_out(channel_pin_out),
   .channel_pin_oe(channel_pin_oe), .irq(irq)
);

//--- test/counter_array_cmp_modes_tb.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; $display("ERROR %s exp %0h got %0h", n, (e), (g)); end end
module counter_array_cmp_modes_tb;
   // ------------------------------------------------------------------
   // signals and design
   // ------------------------------------------------------------------
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic        timebase_tick, pin_in, pin_out, pin_oe, irq, ext_lvl, p;
   logic [31:0] haddr, hwdata, hrdata, rdat;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   int          error_cnt, check_count;
   cacm_channel #(.CHANNELS(1)) uut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .timebase_tick(timebase_tick), .channel_pin_in(pin_in), .channel_pin_out(pin_out),
      .channel_pin_oe(pin_oe), .irq(irq)
   );
   cacm_pin_model pin (.hclk(hclk), .ext_lvl(ext_lvl), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
   assign hready = hreadyout;
   always #12.5 hclk = ~hclk;
   // ------------------------------------------------------------------
   // bus and stimulus tasks
   // ------------------------------------------------------------------
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= cacm_pkg::HTRANS_NSQ;
      haddr  <= {24'h000000, a};
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      rdat = hrdata;
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr
   task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
      xfer(1'b0, a, 32'h00000000);
      `CHK(n, e, rdat & m)
   endtask : rdc
   task automatic tick(input int n);
      repeat (n) begin
         timebase_tick <= 1'b1;
         @(posedge hclk);
         timebase_tick <= 1'b0;
         @(posedge hclk);
      end
      repeat (3) @(posedge hclk);
   endtask : tick
   task automatic pinset(input logic v);
      ext_lvl <= v;
      repeat (6) @(posedge hclk);
   endtask : pinset
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim
   initial begin
      #250000;
      error_cnt++;
      end_sim();
   end
   // ------------------------------------------------------------------
   // tests
   // ------------------------------------------------------------------
   initial begin
      {hclk, hresetn, hsel, hwrite, timebase_tick, ext_lvl, p} = 7'h00;
      {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
      error_cnt = 0;
      check_count = 0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rdc("ctrl", cacm_pkg::ADDR_CTRL, 32'h0);
      rdc("mode", cacm_pkg::ADDR_MODE, 32'h0);
      rdc("pwmcfg", cacm_pkg::ADDR_PWMCFG, 32'h0);
      wr(8'h40, 32'hff);
      rdc("unmapped", 8'h40, 32'h0);
      $display("test reset done");
      wr(cacm_pkg::ADDR_COUNTER, 32'h12ab);
      wr(cacm_pkg::ADDR_MODE, 32'h21);
      pinset(1'b1);
      rdc("cap_lo", cacm_pkg::ADDR_CMP_LO, 32'hab);
      rdc("cap_hi", cacm_pkg::ADDR_CMP_HI, 32'h12);
      repeat (20) @(posedge hclk);
      rdc("evt_hold", cacm_pkg::ADDR_CTRL, 32'h1);
      `CHK("irq", 1'b1, irq)
      wr(cacm_pkg::ADDR_CTRL, 32'h0);
      rdc("evt_clr", cacm_pkg::ADDR_CTRL, 32'h0);
      `CHK("irq_off", 1'b0, irq)
      wr(cacm_pkg::ADDR_COUNTER, 32'h55);
      pinset(1'b0);
      rdc("no_cap", cacm_pkg::ADDR_CTRL, 32'h0);
      wr(cacm_pkg::ADDR_MODE, 32'h30);
      pinset(1'b1);
      rdc("both_lo", cacm_pkg::ADDR_CMP_LO, 32'h55);
      rdc("pin_lvl", cacm_pkg::ADDR_PINLVL, 32'h1);
      `CHK("irq_mask", 1'b0, irq)
      wr(cacm_pkg::ADDR_COUNTER, 32'h66);
      wr(cacm_pkg::ADDR_MODE, 32'h10);
      pinset(1'b0);
      rdc("fall_lo", cacm_pkg::ADDR_CMP_LO, 32'h66);
      $display("test capture done");
      wr(cacm_pkg::ADDR_CTRL, 32'h0);
      wr(cacm_pkg::ADDR_MODE, 32'h48);
      wr(cacm_pkg::ADDR_CMP_LO, 32'h34);
      rdc("cmp_clr", cacm_pkg::ADDR_MODE, 32'h08);
      wr(cacm_pkg::ADDR_CMP_HI, 32'h12);
      rdc("cmp_set", cacm_pkg::ADDR_MODE, 32'h48);
      wr(cacm_pkg::ADDR_COUNTER, 32'h1233);
      wr(cacm_pkg::ADDR_CTRL, 32'h2);
      tick(1);
      rdc("no_match", cacm_pkg::ADDR_CTRL, 32'h2);
      tick(1);
      rdc("match", cacm_pkg::ADDR_CTRL, 32'h3);
      wr(cacm_pkg::ADDR_COUNTER, 32'h1233);
      wr(cacm_pkg::ADDR_CTRL, 32'h2);
      wr(cacm_pkg::ADDR_MODE, 32'h4c);
      p = pin_out;
      tick(2);
      `CHK("hs_tog", ~p, pin_out)
      rdc("hs_evt", cacm_pkg::ADDR_CTRL, 32'h3);
      wr(cacm_pkg::ADDR_CMP_LO, 32'h34);
      wr(cacm_pkg::ADDR_COUNTER, 32'h1234);
      tick(1);
      `CHK("hs_hold", ~p, pin_out)
      $display("test timer done");
      wr(cacm_pkg::ADDR_CMP_LO, 32'h10);
      wr(cacm_pkg::ADDR_CMP_HI, 32'h03);
      wr(cacm_pkg::ADDR_COUNTER, 32'h0f);
      wr(cacm_pkg::ADDR_MODE, 32'h46);
      p = pin_out;
      tick(2);
      `CHK("fq_tog", ~p, pin_out)
      rdc("fq_add", cacm_pkg::ADDR_CMP_LO, 32'h13);
      tick(3);
      `CHK("fq_tog2", p, pin_out)
      wr(cacm_pkg::ADDR_CMP_HI, 32'h00);
      tick(3);
      `CHK("fq_zero", ~p, pin_out)
      tick(255);
      `CHK("fq_wait", ~p, pin_out)
      tick(1);
      `CHK("fq_256", p, pin_out)
      $display("test frequency done");
      wr(cacm_pkg::ADDR_PWMCFG, 32'h20);
      wr(cacm_pkg::ADDR_MODE, 32'h4a);
      wr(cacm_pkg::ADDR_CMP_LO, 32'h80);
      wr(cacm_pkg::ADDR_CMP_HI, 32'h40);
      wr(cacm_pkg::ADDR_COUNTER, 32'h80);
      wr(cacm_pkg::ADDR_CTRL, 32'h2);
      rdc("cycle_overflow_flag_clr", cacm_pkg::ADDR_PWMCFG, 32'h20);
      `CHK("irq_idle", 1'b0, irq)
      tick(1);
      `CHK("pwm8_set", 1'b1, pin_out)
      rdc("pwm8_evt", cacm_pkg::ADDR_CTRL, 32'h3, 32'h0b);
      wr(cacm_pkg::ADDR_COUNTER, 32'hff);
      tick(1);
      `CHK("pwm8_clr", 1'b0, pin_out)
      rdc("reload", cacm_pkg::ADDR_CMP_LO, 32'h40);
      rdc("cycle_overflow_flag", cacm_pkg::ADDR_PWMCFG, 32'h60);
      `CHK("cycle_overflow_flag_irq", 1'b1, irq)
      wr(cacm_pkg::ADDR_MODE, 32'h0a);
      wr(cacm_pkg::ADDR_COUNTER, 32'h13f);
      tick(1);
      `CHK("pwm_off", 1'b0, pin_out)
      wr(cacm_pkg::ADDR_MODE, 32'h42);
      wr(cacm_pkg::ADDR_PWMCFG, 32'h81);
      wr(cacm_pkg::ADDR_CMP_LO, 32'h20);
      rdc("view_mode", cacm_pkg::ADDR_MODE, 32'h42);
      wr(cacm_pkg::ADDR_CMP_HI, 32'h01);
      rdc("view_lo", cacm_pkg::ADDR_CMP_LO, 32'h20);
      wr(cacm_pkg::ADDR_PWMCFG, 32'h01);
      wr(cacm_pkg::ADDR_COUNTER, 32'h1ff);
      tick(1);
      rdc("ar_lo", cacm_pkg::ADDR_CMP_LO, 32'h20);
      rdc("ar_hi", cacm_pkg::ADDR_CMP_HI, 32'h01);
      wr(cacm_pkg::ADDR_COUNTER, 32'h20);
      tick(1);
      `CHK("pwm9_len", 1'b0, pin_out)
      wr(cacm_pkg::ADDR_COUNTER, 32'h120);
      tick(1);
      `CHK("pwm9_set", 1'b1, pin_out)
      wr(cacm_pkg::ADDR_COUNTER, 32'h1ff);
      tick(1);
      `CHK("pwm9_clr", 1'b0, pin_out)
      $display("test short pwm done");
      wr(cacm_pkg::ADDR_MODE, 32'hc2);
      wr(cacm_pkg::ADDR_CMP_LO, 32'h00);
      wr(cacm_pkg::ADDR_CMP_HI, 32'h80);
      wr(cacm_pkg::ADDR_COUNTER, 32'h8000);
      wr(cacm_pkg::ADDR_CTRL, 32'h2);
      tick(1);
      `CHK("pwm16_set", 1'b1, pin_out)
      wr(cacm_pkg::ADDR_COUNTER, 32'hffff);
      tick(1);
      `CHK("pwm16_clr", 1'b0, pin_out)
      rdc("wrap", cacm_pkg::ADDR_CTRL, 32'ha, 32'h0b);
      $display("test wide pwm done");
      end_sim();
   end
endmodule : counter_array_cmp_modes_tb
